// ### pkg/pfd_pkg.sv
// Constants, register map and carrier types of the pixel input format demultiplexer
package pfd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned ITU_CLK_HZ  = 27_000_000;
  localparam int unsigned SYNC_STAGES = 2;

  // ****************************************
  // Pixel bus
  // ****************************************
  localparam int unsigned PIX_LINES = 12;
  localparam int unsigned BYTE_W    = 8;

  localparam logic [2:0] FMT_ITU_422   = 3'h4;
  localparam logic [2:0] FMT_INDEX     = 3'h5;
  localparam logic [2:0] FMT_ALT_444   = 3'h6;

  // Timing reference preamble of the 4:2:2 stream
  localparam logic [7:0] TRS_FIRST = 8'hFF;
  localparam logic [7:0] TRS_ZERO  = 8'h00;

  // ****************************************
  // I2C slave and register map
  // ****************************************
  localparam logic [7:0] I2C_WR_ADDR = 8'h88;

  localparam logic [7:0] OFS_INPUT_PATH  = 8'h37;
  localparam logic [7:0] OFS_LUMA_GAIN   = 8'h38;
  localparam logic [7:0] OFS_CHROMA_GAIN = 8'h39;
  localparam logic [7:0] OFS_PORT_CTRL1  = 8'h3A;
  localparam logic [7:0] OFS_CTRL2       = 8'h54;
  localparam logic [7:0] OFS_FORMAT      = 8'h86;
  localparam logic [7:0] OFS_STATUS      = 8'h87;

  localparam logic [7:0] MSK_INPUT_PATH  = 8'h77;
  localparam logic [7:0] MSK_LUMA_GAIN   = 8'h1F;
  localparam logic [7:0] MSK_CHROMA_GAIN = 8'h1F;
  localparam logic [7:0] MSK_PORT_CTRL1  = 8'hBF;
  localparam logic [7:0] MSK_CTRL2       = 8'hB3;
  localparam logic [7:0] MSK_FORMAT      = 8'h07;

  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h04;

  localparam int unsigned POS_EDGE = 1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] aux;
  } pfd_pix_t;

  typedef struct packed {
    logic                 clk;
    logic [PIX_LINES-1:0] data;
  } pfd_link_t;

endpackage

// ### rtl/pfd_demux.sv
// Pixel input deformatter for formats 4 to 6 with its I2C configuration slave
module pfd_demux
  import pfd_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // Pixel link from the graphics controller
  input  wire logic                 i_pix_clk,
  input  wire logic [PIX_LINES-1:0] i_pix_data,
  // I2C pins
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  // Pixel output
  output pfd_pix_t                  o_pix,
  output logic                      o_pix_valid
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic pfd_pix_t assemble_444(input logic [11:0] f, input logic [11:0] r);
    pfd_pix_t p = '0;
    p.r   = {r[11:7], r[3:1]};
    p.g   = {r[6:4], f[11:9], r[0], f[3]};
    p.b   = {f[8:4], f[2:0]};
    return p;
  endfunction
  // ****************************************
  // Link synchronisers and edge detection
  // ****************************************
  pfd_link_t  link_s1, link_s2;
  logic       pclk_d;
  logic [2:0] link_fill;
  // Edges count only once the pipeline holds real pin samples
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      link_s1   <= '0;
      link_s2   <= '0;
      pclk_d    <= 1'b0;
      link_fill <= 3'h0;
    end else begin
      link_s1   <= {i_pix_clk, i_pix_data};
      link_s2   <= link_s1;
      pclk_d    <= link_s2.clk;
      link_fill <= {link_fill[1:0], 1'b1};
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] input_path_control;
  logic [7:0] rgb_luma_gain;
  logic [7:0] rgb_chroma_diff_gain;
  logic [7:0] input_port_control_first;
  logic [7:0] input_control_second;
  logic [7:0] input_format;
  logic       wr_stb;
  logic [7:0] wr_sub, wr_data;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      input_path_control       <= RST_CTRL;
      rgb_luma_gain            <= RST_CTRL;
      rgb_chroma_diff_gain     <= RST_CTRL;
      input_port_control_first <= RST_CTRL;
      input_control_second     <= RST_CTRL;
      input_format             <= RST_FORMAT;
    end else if (wr_stb) begin
      unique case (wr_sub)
        OFS_INPUT_PATH:  input_path_control       <= wr_data & MSK_INPUT_PATH;
        OFS_LUMA_GAIN:   rgb_luma_gain            <= wr_data & MSK_LUMA_GAIN;
        OFS_CHROMA_GAIN: rgb_chroma_diff_gain     <= wr_data & MSK_CHROMA_GAIN;
        OFS_PORT_CTRL1:  input_port_control_first <= wr_data & MSK_PORT_CTRL1;
        OFS_CTRL2:       input_control_second     <= wr_data & MSK_CTRL2;
        OFS_FORMAT:      input_format             <= wr_data & MSK_FORMAT;
        default: ;
      endcase
    end
  end
  // Edge option swaps which link edge counts as rising
  logic edge_swap, link_edge, pix_rise, pix_fall;
  assign edge_swap = input_control_second[POS_EDGE];
  assign link_edge = link_fill[2] & (link_s2.clk ^ pclk_d);
  assign pix_rise  = link_edge & (link_s2.clk ^ edge_swap);
  assign pix_fall  = link_edge & ~(link_s2.clk ^ edge_swap);
  // ****************************************
  // Pixel demultiplexer
  // ****************************************
  logic [1:0]  slot;
  logic [7:0]  hist0, hist1, hist2;
  logic        trs_locked, half_pend, trs_hit;
  logic [11:0] fall_word;
  pfd_pix_t    acc;
  logic [7:0]  byte_in;
  assign byte_in = link_s2.data[BYTE_W-1:0];
  assign trs_hit = (hist2 == TRS_FIRST) && (hist1 == TRS_ZERO) && (hist0 == TRS_ZERO);
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      slot        <= 2'h0;
      hist0       <= 8'h00;
      hist1       <= 8'h00;
      hist2       <= 8'h00;
      trs_locked  <= 1'b0;
      fall_word   <= 12'h000;
      half_pend   <= 1'b0;
      acc         <= '0;
      o_pix       <= '0;
      o_pix_valid <= 1'b0;
    end else begin
      o_pix_valid <= 1'b0;
      unique case (input_format[2:0])
        FMT_ITU_422: begin
          half_pend <= 1'b0;
          if (pix_rise) begin
            hist0 <= byte_in;
            hist1 <= hist0;
            hist2 <= hist1;
            if (trs_hit) begin
              slot       <= 2'h0;
              trs_locked <= 1'b1;
            end else begin
              slot <= slot + 2'h1;
              unique case (slot)
                2'h0: acc.b <= byte_in;
                2'h1: acc.g <= byte_in;
                2'h2: acc.r <= byte_in;
                2'h3: begin
                  o_pix       <= '{r: acc.r, g: acc.g, b: acc.b, aux: byte_in};
                  o_pix_valid <= 1'b1;
                end
              endcase
            end
          end
        end
        FMT_INDEX: begin
          half_pend <= 1'b0;
          if (pix_fall) begin
            o_pix       <= '{r: 8'h00, g: 8'h00, b: 8'h00, aux: byte_in};
            o_pix_valid <= 1'b1;
          end
        end
        FMT_ALT_444: begin
          if (pix_fall) begin
            fall_word <= link_s2.data;
            half_pend <= 1'b1;
          end else if (pix_rise && half_pend) begin
            o_pix       <= assemble_444(fall_word, link_s2.data);
            o_pix_valid <= 1'b1;
            half_pend   <= 1'b0;
          end
        end
        default: begin
          half_pend  <= 1'b0;
          slot       <= 2'h0;
          trs_locked <= 1'b0;
        end
      endcase
    end
  end
  // ****************************************
  // I2C slave
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} pfd_i2c_st_t;
  pfd_i2c_st_t st;
  logic [2:0]  scl_q, sda_q;
  logic        scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0]  shreg;
  logic [3:0]  bit_cnt;
  logic [1:0]  byte_idx;
  logic        rd_mode, nack;
  logic [7:0]  sub_addr, rd_data, status;
  assign scl_rise   = scl_q[1] & ~scl_q[2];
  assign scl_fall   = ~scl_q[1] & scl_q[2];
  assign start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_cond  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign status     = {4'h0, half_pend, slot, trs_locked};
  always_comb begin
    unique case (sub_addr)
      OFS_INPUT_PATH:  rd_data = input_path_control;
      OFS_LUMA_GAIN:   rd_data = rgb_luma_gain;
      OFS_CHROMA_GAIN: rd_data = rgb_chroma_diff_gain;
      OFS_PORT_CTRL1:  rd_data = input_port_control_first;
      OFS_CTRL2:       rd_data = input_control_second;
      OFS_FORMAT:      rd_data = input_format;
      OFS_STATUS:      rd_data = status;
      default:         rd_data = 8'h00;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st        <= ST_IDLE;
      shreg     <= 8'h00;
      bit_cnt   <= 4'h0;
      byte_idx  <= 2'h0;
      rd_mode   <= 1'b0;
      nack      <= 1'b0;
      sub_addr  <= 8'h00;
      wr_stb    <= 1'b0;
      wr_sub    <= 8'h00;
      wr_data   <= 8'h00;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        st       <= ST_RX;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        st       <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (st)
          ST_IDLE: o_sda_oe <= 1'b0;
          ST_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_q[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'h0) begin
                if (shreg[7:1] == I2C_WR_ADDR[7:1]) begin
                  rd_mode  <= shreg[0];
                  st       <= ST_ACK;
                  o_sda_oe <= 1'b1;
                end else begin
                  st <= ST_IDLE;
                end
              end else begin
                if (byte_idx == 2'h1) begin
                  sub_addr <= shreg;
                end else begin
                  wr_stb   <= 1'b1;
                  wr_sub   <= sub_addr;
                  wr_data  <= shreg;
                  sub_addr <= sub_addr + 8'h01;
                end
                st       <= ST_ACK;
                o_sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              byte_idx <= byte_idx + {1'b0, ~byte_idx[1]};
              if (rd_mode) begin
                shreg    <= rd_data;
                o_sda_oe <= ~rd_data[7];
                bit_cnt  <= 4'h1;
                st       <= ST_TX;
              end else begin
                o_sda_oe <= 1'b0;
                st       <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                o_sda_oe <= 1'b0;
                st       <= ST_TXACK;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                o_sda_oe <= ~shreg[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              nack     <= sda_q[1];
              sub_addr <= sub_addr + {7'h00, ~sda_q[1]};
            end else if (scl_fall) begin
              if (nack) begin
                st <= ST_IDLE;
              end else begin
                shreg    <= rd_data;
                o_sda_oe <= ~rd_data[7];
                bit_cnt  <= 4'h1;
                st       <= ST_TX;
              end
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ### tb/pfd_demux_checker.sv
// Port-level assertions for the pixel input format demultiplexer
module pfd_demux_checker
  import pfd_pkg::*;
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  // Watched ports
  input wire logic                 i_pix_clk,
  input wire logic [PIX_LINES-1:0] i_pix_data,
  input wire logic                 i_scl,
  input wire logic                 i_sda,
  input wire logic                 o_sda_out,
  input wire logic                 o_sda_oe,
  input wire pfd_pix_t             o_pix,
  input wire logic                 o_pix_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  chk_valid_gap: assert property (o_pix_valid |=> !o_pix_valid [*6])
    else $error("pixel valid repeated");
  chk_pix_held: assert property (o_pix_valid |=> $stable(o_pix) [*6])
    else $error("pixel changed while held");
  chk_pix_source: assert property ($changed(o_pix) |-> o_pix_valid)
    else $error("pixel changed without valid");
  chk_link_cause: assert property (!$changed(i_pix_clk) [*7] |-> !o_pix_valid)
    else $error("pixel valid without link edge");
  chk_sda_open: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  chk_ack_rise: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data pulled while clock high");
  chk_ack_fall: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("data released while clock high");
  chk_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("data pull too short");
endmodule

bind pfd_demux pfd_demux_checker chk_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_pix_clk(i_pix_clk), .i_pix_data(i_pix_data),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_pix(o_pix), .o_pix_valid(o_pix_valid)
);

// ### tb/pfd_gfx_model.sv
// Graphics controller model driving the pixel link
module pfd_gfx_model
  import pfd_pkg::*;
(
  // Clock
  input  wire logic             i_clk,
  // Pixel link
  output logic                  o_pix_clk,
  output logic [PIX_LINES-1:0]  o_pix_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_pix_clk = 1'b1;
    o_pix_data = 12'h000;
  end

  // Data set a quarter period ahead of its edge
  task automatic edge_out(input logic lvl, input logic [11:0] w);
    repeat (2) @(posedge i_clk);
    o_pix_data <= w;
    repeat (2) @(posedge i_clk);
    o_pix_clk <= lvl;
  endtask

  task automatic pixel(input logic [11:0] f, input logic [11:0] r);
    edge_out(1'b0, f);
    edge_out(1'b1, r);
  endtask

  // Hold ends, so lines stop showing the last value
  task automatic idle();
    repeat (2) @(posedge i_clk);
    o_pix_data <= ~o_pix_data;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking testbench for the pixel input format demultiplexer
module tb_top
  import pfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 6;

  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_scl = 1'b1;
  logic        sda_drv = 1'b1;
  logic        sda_w, pix_clk, sda_out, sda_oe, pix_valid;
  logic [11:0] pix_data;
  pfd_pix_t    pix;
  pfd_pix_t    got[$], exp[$];
  int          fail_count = 0, total_checks = 0, cycles = 0;
  logic [7:0]  itu[8] = '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h11, 8'h22, 8'h33, 8'h44};
  logic [23:0] fmt6[3] = '{24'hABC5E7, 24'hFFF000, 24'h000FFF};

  assign sda_w = sda_drv & ~sda_oe;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (pix_valid === 1'b1) got.push_back(pix);

  pfd_gfx_model gfx (.i_clk(i_clk), .o_pix_clk(pix_clk), .o_pix_data(pix_data));
  pfd_demux uut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_pix_clk(pix_clk), .i_pix_data(pix_data),
    .i_scl(i_scl), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_pix(pix), .o_pix_valid(pix_valid)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkpix(input pfd_pix_t e, input pfd_pix_t g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected pixel: expected %h seen %h", e, g);
    end
  endtask

  function automatic pfd_pix_t pix6(input logic [11:0] f, input logic [11:0] r);
    pix6 = {r[11:7], r[3:1], r[6:4], f[11:9], r[0], f[3], f[8:4], f[2:0], 8'h00};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // ****************************************
  // Serial configuration access
  // ****************************************
  task automatic start();
    sda_drv <= 1'b1;
    tick(Q);
    i_scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b0;
    tick(Q);
    i_scl <= 1'b0;
    tick(Q);
  endtask

  task automatic stop();
    sda_drv <= 1'b0;
    tick(Q);
    i_scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b1;
    tick(Q);
  endtask

  // Eight bits and the acknowledge slot, MSB first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= tx[i];
      tick(Q);
      i_scl <= 1'b1;
      tick(Q);
      rx[i] = sda_w;
      i_scl <= 1'b0;
      tick(Q);
    end
  endtask

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic [8:0] a0, a1, a2;
    start();
    xfer({I2C_WR_ADDR, 1'b1}, a0);
    xfer({sub, 1'b1}, a1);
    xfer({d, 1'b1}, a2);
    stop();
    chk8("write acks", 8'h00, {5'h00, a0[0], a1[0], a2[0]});
    chk8("data drive", 8'h00, {7'h00, sda_out});
  endtask

  task automatic rd(input logic [7:0] sub, input logic [7:0] e);
    logic [8:0] a0, a1, a2, v;
    start();
    xfer({I2C_WR_ADDR, 1'b1}, a0);
    xfer({sub, 1'b1}, a1);
    start();
    xfer({I2C_WR_ADDR | 8'h01, 1'b1}, a2);
    xfer(9'h1FF, v);
    stop();
    chk8("read acks", 8'h00, {5'h00, a0[0], a1[0], a2[0]});
    chk8("register", e, v[8:1]);
  endtask

  task automatic flush();
    gfx.idle();
    tick(12);
    chk8("pixel count", 8'(exp.size()), 8'(got.size()));
    foreach (exp[i]) chkpix(exp[i], got[i]);
    exp.delete();
    got.delete();
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    tick(16);
    i_rstn <= 1'b1;
    tick(2);
    rd(OFS_FORMAT, RST_FORMAT);
    rd(OFS_INPUT_PATH, RST_CTRL);
    wr(OFS_LUMA_GAIN, 8'hFF);
    rd(OFS_LUMA_GAIN, MSK_LUMA_GAIN);
    wr(8'h60, 8'hAA);
    foreach (itu[i]) gfx.pixel({4'hA, ~itu[i]}, {4'h5, itu[i]});
    exp.push_back({8'h33, 8'h22, 8'h11, 8'h44});
    flush();
    rd(OFS_STATUS, 8'h01);
    wr(OFS_FORMAT, {5'h00, FMT_INDEX});
    gfx.pixel(12'hF5C, 12'hFFF);
    gfx.pixel(12'h0A3, 12'h123);
    exp.push_back({24'h000000, 8'h5C});
    exp.push_back({24'h000000, 8'hA3});
    flush();
    wr(OFS_CTRL2, 8'h02);
    rd(OFS_CTRL2, 8'h02);
    gfx.pixel(12'h0B1, 12'hE96);
    exp.push_back({24'h000000, 8'h96});
    flush();
    wr(OFS_CTRL2, 8'h00);
    wr(OFS_FORMAT, {5'h00, FMT_ALT_444});
    foreach (fmt6[i]) begin
      gfx.pixel(fmt6[i][23:12], fmt6[i][11:0]);
      exp.push_back(pix6(fmt6[i][23:12], fmt6[i][11:0]));
    end
    flush();
    wr(OFS_FORMAT, 8'h07);
    gfx.pixel(12'h123, 12'h456);
    flush();
    rd(OFS_STATUS, 8'h00);
    conclude();
  end
endmodule
